// ### xdm_pkg.sv
// Constants and types shared by the external data memory interface
package xdm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets on the APB (byte addresses)
    localparam logic [7:0] OFS_PAGE = 8'h00;
    localparam logic [7:0] OFS_CFG  = 8'h04;
    localparam logic [7:0] OFS_TIME = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;

    // Reset values
    localparam logic [7:0] PAGE_RST = 8'h00;
    localparam logic [5:0] CFG_RST  = 6'h03;
    localparam logic [7:0] TIME_RST = 8'hff;

    // Configuration fields
    localparam int CFG_BANK  = 5;
    localparam int CFG_NOMUX = 4;
    localparam int CFG_MODE  = 2;
    localparam int CFG_ALE   = 0;

    // Timing fields
    localparam int TIME_SET = 6;
    localparam int TIME_STB = 2;
    localparam int TIME_HLD = 0;

    // Status fields
    localparam int STAT_BUSY = 0;
    localparam int STAT_OFF  = 1;

    ////////////////////////////////////////////////////////////////////////
    // Pin group of one port bank
    localparam int PIN_W   = 27;
    localparam int PIN_AD  = 0;
    localparam int PIN_ALO = 8;
    localparam int PIN_AHI = 16;
    localparam int PIN_ALE = 24;
    localparam int PIN_RD  = 25;
    localparam int PIN_WR  = 26;

    // Fixed cycles of every off-chip access
    localparam logic [5:0] ACC_FIXED = 6'h04;

    // Size of the on-chip RAM (8 k)
    localparam int RAM_AW = 13;

    typedef enum logic [1:0] {
        MM_ONCHIP = 2'b00,
        MM_SPLIT  = 2'b01,
        MM_BANK   = 2'b10,
        MM_EXT    = 2'b11
    } xdm_mode_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RAM,
        ST_LEAD,
        ST_ALEH,
        ST_ALEL,
        ST_SETUP,
        ST_STB,
        ST_HOLD,
        ST_TAIL
    } xdm_state_t;

endpackage

// ### xdm_ram_if.sv
// Signals between the access sequencer and the on-chip RAM
`timescale 1ns/10ps
`default_nettype none
interface xdm_ram_if;
    import xdm_pkg::*;
    logic              en;
    logic              we;
    logic [RAM_AW-1:0] addr;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    modport ctrl (output en, we, addr, wdata, input rdata);
    modport mem  (input en, we, addr, wdata, output rdata);
endinterface
`default_nettype wire

// ### xdm_ram.sv
// On-chip data RAM with registered read data
`timescale 1ns/10ps
`default_nettype none
module xdm_ram
    import xdm_pkg::*;
(
    input  wire logic clock,
    input  wire logic arst_n,
    xdm_ram_if.mem    bus
);
    logic [7:0] store [2**RAM_AW];

    // Array kept free of reset so it maps onto a plain RAM macro
    always_ff @(posedge clock) begin
        if (bus.en && bus.we) begin
            store[bus.addr] <= bus.wdata;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bus.rdata <= 8'h00;
        end else if (bus.en) begin
            bus.rdata <= store[bus.addr];
        end
    end
endmodule
`default_nettype wire

// ### xdm_top.sv
// External data memory interface: on-chip RAM and off-chip bus sequencer
//
// What this block and its external latch do
// RULE1: Bank bit selects lower or upper ports
// RULE2: Mux bit picks shared or separate pins
// RULE3: Shared pins carry address and data, strobe latch
// RULE4: Latch strobe high with address, then falls
// RULE5: External latch transparent high, holds after fall
// RULE6: Shared pins carry data during read/write strobe
// RULE7: Non-multiplexed: separate address and data pins
// RULE8: Mode 00: all on chip, wrap 8 k
// RULE9: 8-bit form page plus index; else pointer
// RULE10: Mode 01: split at 8 k by address
// RULE11: Split without bank: upper address undriven
// RULE12: Pointer access picks side, drives sixteen bits
// RULE13: Mode 10: page drives upper address bits
// RULE14: Mode 11: all off chip, page ignored
// RULE15: External-only pointer access drives full address
// RULE16: Latch strobe high/low widths from field
// RULE17: Access is setup+strobe+hold plus four
// RULE18: Multiplexed adds latch strobe cycles, minimum seven
// RULE19: Setup and hold reset to maximum
// RULE20: Pins claimed only during off-chip access
// RULE21: Input pins released during off-chip access
// RULE22: One active-low strobe, inside strobe window
// RULE23: On-chip accesses leave all pins quiet
`timescale 1ns/10ps
`default_nettype none
module xdm_top
    import xdm_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   arst_n,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   cpu_req,
    input  wire logic                   cpu_write,
    input  wire logic                   cpu_wide,
    input  wire logic [15:0]            cpu_pointer,
    input  wire logic [7:0]             cpu_index,
    input  wire logic [7:0]             cpu_wdata,
    output logic                        cpu_busy,
    output logic                        cpu_ack,
    output logic      [7:0]             cpu_rdata,
    input  wire logic [1:0][PIN_W-1:0]  pin_in,
    output logic      [1:0][PIN_W-1:0]  pin_out,
    output logic      [1:0][PIN_W-1:0]  pin_oe
);
    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]  page;
    logic [5:0]  cfg;
    logic [7:0]  timing;
    logic        last_off;
    xdm_state_t  state;
    xdm_state_t  next_state;
    logic [3:0]  cnt;
    logic [3:0]  next_cnt;
    logic [15:0] acc_addr;
    logic [7:0]  acc_wdata;
    logic        acc_write;
    logic        acc_mux;
    logic        acc_bank;
    logic        acc_hi;
    logic [1:0]  acc_set;
    logic [3:0]  acc_stb;
    logic [1:0]  acc_hld;
    logic [1:0]  acc_ale;
    logic        stb_end;
    logic [PIN_W-1:0] next_out;
    logic [PIN_W-1:0] next_oe;

    xdm_ram_if ram_bus ();

    xdm_ram u_ram (
        .clock  (clock),
        .arst_n (arst_n),
        .bus    (ram_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state so read data leaves a flip-flop
    wire        apb_sel  = psel & penable;
    wire        hit_page = paddr == OFS_PAGE;
    wire        hit_cfg  = paddr == OFS_CFG;
    wire        hit_time = paddr == OFS_TIME;
    wire        hit_stat = paddr == OFS_STAT;
    wire        hit_any  = hit_page | hit_cfg | hit_time | hit_stat;
    wire        apb_wr   = apb_sel & pready & pwrite;
    wire [31:0] rd_page  = {24'h000000, page};
    wire [31:0] rd_cfg   = {26'h0000000, cfg};
    wire [31:0] rd_time  = {24'h000000, timing};
    wire [31:0] rd_stat  = {30'h0, last_off, cpu_busy};
    wire [31:0] rd_mux   = hit_page ? rd_page : hit_cfg ? rd_cfg :
                           hit_time ? rd_time : hit_stat ? rd_stat : 32'h00000000;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= apb_sel & ~pready;
            pslverr <= apb_sel & ~pready & ~hit_any;
            prdata  <= (apb_sel & ~pready) ? rd_mux : 32'h00000000;
        end
    end

    // Bits 7:6 of the configuration are not stored and read as zero
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            page   <= PAGE_RST;
            cfg    <= CFG_RST;
            timing <= TIME_RST; // RULE19
        end else if (apb_wr) begin
            if (hit_page) page <= pwdata[7:0];
            if (hit_cfg) cfg <= pwdata[5:0];
            if (hit_time) timing <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address decode for a new request
    wire [1:0]  mode     = cfg[CFG_MODE+:2];
    wire [15:0] eff      = cpu_wide ? cpu_pointer : {page, cpu_index}; // RULE9
    wire        low8k    = eff[15:13] == 3'b000;
    wire        is_split = (mode == MM_SPLIT) | (mode == MM_BANK);
    wire        go_off   = (mode == MM_EXT) | (is_split & ~low8k); // RULE8 RULE10 RULE12 RULE14
    wire        take     = cpu_req & (state == ST_IDLE);
    wire        hi_drv   = cpu_wide | (mode == MM_BANK); // RULE11 RULE13 RULE15

    assign ram_bus.en    = take & ~go_off;
    assign ram_bus.we    = cpu_write;
    assign ram_bus.addr  = eff[RAM_AW-1:0]; // RULE8
    assign ram_bus.wdata = cpu_wdata;

    // Timing is frozen at request so a register write cannot bend a cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            acc_addr  <= 16'h0000;
            acc_wdata <= 8'h00;
            acc_write <= 1'b0;
            acc_mux   <= 1'b0;
            acc_bank  <= 1'b0;
            acc_hi    <= 1'b0;
            acc_set   <= 2'h0;
            acc_stb   <= 4'h0;
            acc_hld   <= 2'h0;
            acc_ale   <= 2'h0;
            last_off  <= 1'b0;
        end else if (take) begin
            acc_addr  <= eff;
            acc_wdata <= cpu_wdata;
            acc_write <= cpu_write;
            acc_mux   <= ~cfg[CFG_NOMUX]; // RULE2
            acc_bank  <= cfg[CFG_BANK];
            acc_hi    <= hi_drv;
            acc_set   <= timing[TIME_SET+:2];
            acc_stb   <= timing[TIME_STB+:4];
            acc_hld   <= timing[TIME_HLD+:2];
            acc_ale   <= cfg[CFG_ALE+:2]; // RULE16
            last_off  <= go_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer
    wire [3:0] cnt_dec = (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
    wire       phase_end = cnt == 4'h0;

    always_comb begin
        next_state = state;
        next_cnt   = cnt_dec;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    next_state = go_off ? ST_LEAD : ST_RAM;
                    next_cnt   = 4'h0;
                end
            end
            ST_RAM: next_state = ST_IDLE;
            ST_LEAD, ST_ALEL: begin
                if (acc_mux && state == ST_LEAD) begin
                    next_state = ST_ALEH; // RULE18
                    next_cnt   = {2'b00, acc_ale};
                end else if (phase_end && acc_set != 2'h0) begin
                    next_state = ST_SETUP;
                    next_cnt   = {2'b00, acc_set - 2'h1};
                end else if (phase_end) begin
                    next_state = ST_STB;
                    next_cnt   = acc_stb;
                end
            end
            ST_ALEH: begin
                if (phase_end) begin
                    next_state = ST_ALEL; // RULE16
                    next_cnt   = {2'b00, acc_ale};
                end
            end
            ST_SETUP: begin
                if (phase_end) begin
                    next_state = ST_STB;
                    next_cnt   = acc_stb;
                end
            end
            ST_STB, ST_HOLD: begin
                if (phase_end && state == ST_STB && acc_hld != 2'h0) begin
                    next_state = ST_HOLD;
                    next_cnt   = {2'b00, acc_hld - 2'h1};
                end else if (phase_end) begin
                    next_state = ST_TAIL; // RULE17
                    next_cnt   = 4'h1;
                end
            end
            ST_TAIL: begin
                if (phase_end) next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state    <= ST_IDLE;
            cnt      <= 4'h0;
            cpu_busy <= 1'b0;
            stb_end  <= 1'b0;
        end else begin
            state    <= next_state;
            cnt      <= next_cnt;
            cpu_busy <= next_state != ST_IDLE;
            stb_end  <= (state == ST_STB) & phase_end;
        end
    end

    // Read data is taken at the end of the last shown strobe cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cpu_ack   <= 1'b0;
            cpu_rdata <= 8'h00;
        end else begin
            cpu_ack <= (state == ST_RAM) | ((state == ST_TAIL) & phase_end);
            if (state == ST_RAM && !acc_write) begin
                cpu_rdata <= ram_bus.rdata;
            end else if (stb_end && !acc_write) begin
                cpu_rdata <= pin_in[acc_bank][PIN_AD+:8]; // RULE6
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin values for the state; shown one cycle later from flip-flops
    wire claim  = (state == ST_LEAD) | (state == ST_ALEH) | (state == ST_ALEL) |
                  (state == ST_SETUP) | (state == ST_STB) | (state == ST_HOLD);
    wire in_ale = (state == ST_ALEH) | (state == ST_ALEL);
    wire in_stb = state == ST_STB;

    always_comb begin
        next_out = '0;
        next_oe  = '0;
        if (claim) begin // RULE20
            next_oe[PIN_RD]  = 1'b1;
            next_oe[PIN_WR]  = 1'b1;
            next_out[PIN_RD] = ~(in_stb & ~acc_write); // RULE22
            next_out[PIN_WR] = ~(in_stb & acc_write); // RULE22
            if (acc_hi) begin
                next_out[PIN_AHI+:8] = acc_addr[15:8]; // RULE12 RULE13 RULE15
                next_oe[PIN_AHI+:8]  = 8'hff;
            end
            if (acc_mux) begin
                next_oe[PIN_ALE]  = 1'b1; // RULE3
                next_out[PIN_ALE] = state == ST_ALEH; // RULE4
                if (in_ale) begin
                    next_out[PIN_AD+:8] = acc_addr[7:0]; // RULE3 RULE4
                    next_oe[PIN_AD+:8]  = 8'hff;
                end else if (acc_write && state != ST_LEAD) begin
                    next_out[PIN_AD+:8] = acc_wdata; // RULE6
                    next_oe[PIN_AD+:8]  = 8'hff;
                end
            end else begin
                next_out[PIN_ALO+:8] = acc_addr[7:0]; // RULE7
                next_oe[PIN_ALO+:8]  = 8'hff;
                if (acc_write) begin
                    next_out[PIN_AD+:8] = acc_wdata; // RULE7
                    next_oe[PIN_AD+:8]  = 8'hff; // RULE21
                end
            end
        end
    end

    // Unselected bank stays released to its port latches
    for (genvar b = 0; b < 2; b++) begin : g_bank
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                pin_out[b] <= '0;
                pin_oe[b]  <= '0;
            end else begin
                pin_out[b] <= (acc_bank == 1'(b)) ? next_out : '0; // RULE1
                pin_oe[b]  <= (acc_bank == 1'(b)) ? next_oe : '0; // RULE1
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    wire [PIN_W-1:0] sel_out = pin_out[acc_bank];
    wire [PIN_W-1:0] sel_oe  = pin_oe[acc_bank];
    wire shown  = sel_oe[PIN_RD];
    wire rd_low = shown & ~sel_out[PIN_RD];
    wire wr_low = shown & ~sel_out[PIN_WR];
    logic [5:0] len_cnt;
    logic       first_cyc;
    wire  [5:0] mux_len = acc_mux ? {3'b000, acc_ale, 1'b0} + 6'h02 : 6'h00;
    wire  [5:0] exp_len = ACC_FIXED + {4'h0, acc_set} + {2'h0, acc_stb} + 6'h01 +
                          {4'h0, acc_hld} + mux_len;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            len_cnt   <= 6'h00;
            first_cyc <= 1'b1;
        end else begin
            len_cnt   <= take ? 6'h01 : (state != ST_IDLE) ? len_cnt + 6'h01 : len_cnt;
            first_cyc <= 1'b0;
        end
    end

    sequence s_addr_on_ad;
        sel_oe[PIN_AD+:8] == 8'hff && sel_out[PIN_AD+:8] == acc_addr[7:0];
    endsequence
    sequence s_strobe_on;
        rd_low || wr_low;
    endsequence
    property p_ale_then_strobe;
        $fell(sel_out[PIN_ALE]) && shown |-> s_addr_on_ad ##[0:24] s_strobe_on;
    endproperty

    chk_strobe_excl: assert property (!(rd_low && wr_low)) // RULE22
        else $error("read and write strobes both low");
    chk_ale_start: assert property ($rose(sel_out[PIN_ALE]) |-> s_addr_on_ad) // RULE4
        else $error("latch strobe rose without low address on shared pins");
    chk_ale_order: assert property (p_ale_then_strobe) // RULE4
        else $error("no strobe after latch strobe fell");
    chk_read_release: assert property (rd_low |-> sel_oe[PIN_AD+:8] == 8'h00) // RULE21
        else $error("data pins driven during read strobe");
    chk_write_data: assert property (wr_low |-> sel_oe[PIN_AD+:8] == 8'hff &&
                                     sel_out[PIN_AD+:8] == acc_wdata) // RULE6
        else $error("write data not on data pins during write strobe");
    chk_hi_float: assert property (shown && !acc_hi |-> sel_oe[PIN_AHI+:8] == 8'h00) // RULE11
        else $error("upper address driven in 8-bit no-bank access");
    chk_hi_drive: assert property (shown && acc_hi |-> sel_out[PIN_AHI+:8] == acc_addr[15:8]) // RULE13
        else $error("upper address wrong in full-address access");
    chk_bank_other: assert property (pin_oe[~acc_bank] == '0) // RULE1
        else $error("unselected port bank driven");
    chk_ram_quiet: assert property (state == ST_RAM |-> pin_oe == '0 ##1 pin_oe == '0) // RULE23
        else $error("pins moved during on-chip access");
    chk_mode_zero: assert property (take && mode == MM_ONCHIP |=> state == ST_RAM) // RULE8
        else $error("mode 00 access left the chip");
    chk_access_len: assert property (cpu_ack && last_off |-> len_cnt == exp_len) // RULE17
        else $error("off-chip access length wrong");
    chk_timing_reset: assert property (first_cyc |-> timing == TIME_RST) // RULE19
        else $error("timing not at maximum after reset");
endmodule
`default_nettype wire

// ### xdm_sram_model.sv
// Behavioural external SRAM behind an address latch, seen through one pin bank
`timescale 1ns/10ps
`default_nettype none
module xdm_sram_model
    import xdm_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             nomux,
    input  wire logic [PIN_W-1:0] pin_out,
    input  wire logic [PIN_W-1:0] pin_oe,
    output logic      [PIN_W-1:0] pin_in
);
    logic [7:0]       mem [0:65535];
    logic [7:0]       latch_q;
    logic [15:0]      addr;
    logic [PIN_W-1:0] level;
    logic             rd_on;
    logic             wr_on;

    ////////////////////////////////////////////////////////////////////////
    // Undriven pins sit at the parked port level, so a stale value never shows
    assign level = (pin_oe & pin_out) | ~pin_oe;
    assign rd_on = !level[PIN_RD];
    assign wr_on = !level[PIN_WR];
    always_latch begin
        if (level[PIN_ALE]) begin
            latch_q <= level[PIN_AD+:8];
        end
    end
    assign addr   = {level[PIN_AHI+:8], nomux ? level[PIN_ALO+:8] : latch_q};
    assign pin_in = {level[PIN_W-1:8], rd_on ? mem[addr] : level[PIN_AD+:8]};
    always @(posedge clock) begin
        if (wr_on) begin
            mem[addr] <= level[PIN_AD+:8];
        end
    end
endmodule
`default_nettype wire

// ### xdm_top_tb.sv
// Self-checking testbench for the external data memory interface
`timescale 1ns/10ps
`default_nettype none
module xdm_top_tb;
    import xdm_pkg::*;
    localparam logic [PIN_W-1:0] PULLED = {PIN_W{1'b1}};
    logic                  clock, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic                  cpu_req, cpu_write, cpu_wide, cpu_busy, cpu_ack, bank, nomux;
    logic [7:0]            paddr, cpu_index, cpu_wdata, cpu_rdata, rb;
    logic [15:0]           cpu_pointer;
    logic [31:0]           pwdata, prdata, rw;
    logic [1:0][PIN_W-1:0] pin_in, pin_out, pin_oe;
    logic [PIN_W-1:0]      mdl_in, mdl_out, mdl_oe, oe_acc;
    logic [1:0]            bank_acc;
    int                    errors, n_checks, n, ale_n, rd_n, wr_n;

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    xdm_top u_xdm_top (.clock, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cpu_req, .cpu_write, .cpu_wide, .cpu_pointer, .cpu_index,
        .cpu_wdata, .cpu_busy, .cpu_ack, .cpu_rdata, .pin_in, .pin_out, .pin_oe);
    xdm_sram_model u_xdm_sram_model (.clock, .nomux, .pin_out(mdl_out), .pin_oe(mdl_oe),
        .pin_in(mdl_in));
    // The idle bank only sees its weak pull-ups
    assign mdl_out = pin_out[bank];
    assign mdl_oe  = pin_oe[bank];
    assign pin_in  = bank ? {mdl_in, PULLED} : {PULLED, mdl_in};

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp, input string m);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    function automatic logic [7:0] mm(input logic [15:0] a);
        return u_xdm_sram_model.mem[a];
    endfunction
    // Pin activity of each access, counted cycle by cycle
    always @(posedge clock) begin
        oe_acc = oe_acc | mdl_oe;
        bank_acc = bank_acc | {|pin_oe[1], |pin_oe[0]};
        ale_n += int'(mdl_oe[PIN_ALE] && mdl_out[PIN_ALE]);
        rd_n += int'(mdl_oe[PIN_RD] && !mdl_out[PIN_RD]);
        wr_n += int'(mdl_oe[PIN_WR] && !mdl_out[PIN_WR]);
        if (mdl_oe[PIN_RD] && !mdl_out[PIN_RD]) begin
            chk(32'({mdl_oe[PIN_WR] && !mdl_out[PIN_WR], |mdl_oe[7:0]}), 0, "read clash");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One idle cycle before each transfer keeps psel from being set twice at one edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never gets an answer
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rw = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cfg(input logic [5:0] c, input logic [7:0] t, pg);
        bank = c[CFG_BANK];
        nomux = c[CFG_NOMUX];
        apb(1'b1, OFS_CFG, {26'h0, c});
        apb(1'b1, OFS_TIME, {24'h0, t});
        apb(1'b1, OFS_PAGE, {24'h0, pg});
    endtask
    // n counts edges from the take edge to the one that samples the ack
    task automatic cpu(input logic w, wide, input logic [15:0] p, input logic [7:0] x, d);
        @(posedge clock);
        oe_acc = '0;
        bank_acc = '0;
        ale_n = 0;
        rd_n = 0;
        wr_n = 0;
        cpu_req <= 1'b1;
        cpu_write <= w;
        cpu_wide <= wide;
        cpu_pointer <= p;
        cpu_index <= x;
        cpu_wdata <= d;
        @(posedge clock);
        cpu_req <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (n == 1) chk(32'(cpu_busy), 1, "busy during access");
        end while (cpu_ack !== 1'b1);
        rb = cpu_rdata;
        chk(32'(|pin_oe), 0, "pins kept after access");
    endtask
    task automatic off(input int len, input logic [7:0] hi);
        chk(32'(n), 32'(len), "access length");
        chk(32'(oe_acc[PIN_AHI+:8]), 32'(hi), "upper address drive");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clock);
        errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {arst_n, psel, penable, pwrite, cpu_req, cpu_write, cpu_wide, bank, nomux} = '0;
        {paddr, cpu_index, cpu_wdata, cpu_pointer, pwdata} = '0;
        {errors, n_checks} = '0;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        apb(1'b0, OFS_CFG, 0);
        chk(rw, 32'h03, "config reset");
        apb(1'b0, OFS_TIME, 0);
        chk(rw, 32'hff, "timing reset");
        apb(1'b0, 8'h10, 0);
        chk(32'(err), 1, "unmapped offset");
        $display("test reset done");
        cfg(6'h1c, 8'hff, 8'h12);
        cpu(1'b1, 1'b1, 16'h1234, 8'h00, 8'ha5);
        off(26, 8'hff);
        chk(32'(wr_n), 16, "write strobe width");
        chk(32'(oe_acc[PIN_ALO+:8]), 32'hff, "separate address");
        chk(mm(16'h1234), 8'ha5, "pointer write");
        apb(1'b0, OFS_STAT, 0);
        chk(rw, 32'h2, "status after off-chip access");
        cpu(1'b0, 1'b1, 16'h1234, 8'h00, 8'h00);
        chk({rb, 8'(rd_n + wr_n)}, 16'ha510, "pointer read");
        cpu(1'b1, 1'b0, 16'h0000, 8'h56, 8'h3c);
        off(26, 8'h00);
        chk(mm(16'hff56), 8'h3c, "page ignored");
        $display("test external only done");
        cfg(6'h18, 8'h00, 8'h52);
        cpu(1'b1, 1'b0, 16'h0000, 8'h34, 8'h5a);
        off(5, 8'hff);
        chk(mm(16'h5234), 8'h5a, "banked write");
        apb(1'b1, OFS_PAGE, 0);
        cpu(1'b0, 1'b0, 16'h0000, 8'h34, 8'h00);
        chk({n[4:0], oe_acc}, {5'd2, 27'h0}, "on-chip below boundary");
        cfg(6'h14, 8'h00, 8'h40);
        cpu(1'b1, 1'b0, 16'h0000, 8'h78, 8'h66);
        off(5, 8'h00);
        chk(mm(16'hff78), 8'h66, "upper left parked");
        cpu(1'b0, 1'b1, 16'h1fff, 8'h00, 8'h00);
        chk(32'(n), 2, "pointer on chip");
        cpu(1'b0, 1'b1, 16'hff78, 8'h00, 8'h00);
        off(5, 8'hff);
        chk(rb, 8'h66, "pointer off chip");
        $display("test split modes done");
        cfg(6'h10, 8'h00, 8'h00);
        cpu(1'b1, 1'b1, 16'h2005, 8'h00, 8'h11);
        cpu(1'b0, 1'b1, 16'h4005, 8'h00, 8'h00);
        chk(rb, 8'h11, "wrap at 8 k");
        cpu(1'b0, 1'b0, 16'h0000, 8'h05, 8'h00);
        chk(32'(rb), 8'h11, "page and index on chip");
        chk(32'(oe_acc), 0, "pins quiet on chip");
        $display("test on-chip done");
        for (int a = 0; a < 4; a++) begin
            cfg(6'h2c | 6'(a), 8'h00, 8'h00);
            cpu(1'b1, 1'b1, {8'hc3, 8'(a)}, 8'h00, 8'(8'h80 + a));
            off(7 + 2 * a, 8'hff);
            chk(32'(ale_n), 32'(a + 1), "latch strobe high time");
            chk({bank_acc, oe_acc[PIN_ALO+:8]}, 10'h200, "bank and shared pins");
            cpu(1'b0, 1'b1, {8'hc3, 8'(a)}, 8'h00, 8'h00);
            chk(rb, 8'(8'h80 + a), "multiplexed read back");
        end
        $display("test multiplexed done");
        finish_test();
    end
endmodule
`default_nettype wire
